// File: hdl/mbs_crc16.v
/*
  Byte-wide frame check sequence engine, one byte per clock.
  Assumes init and en are never high together; init wins if they are.
*/
`include "mbs_regs.vh"

module mbs_crc16 (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        init,
  input  wire        en,
  input  wire [7:0]  data,
  output reg  [15:0] crc
);

  reg     [15:0] next_crc;
  integer        k;

  // Reflected shift of eight bits at once
  always @* begin
    next_crc = crc ^ {8'h00, data};
    for (k = 0; k < 8; k = k + 1) begin
      if (next_crc[0]) begin
        next_crc = (next_crc >> 1) ^ `MBS_CRC_POLY;
      end else begin
        next_crc = next_crc >> 1;
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crc <= `MBS_CRC_INIT;
    end else if (init) begin
      crc <= `MBS_CRC_INIT;
    end else if (en) begin
      crc <= next_crc;
    end
  end

endmodule

// File: hdl/mbs_regs.vh
/*
  Constants of the serial slave port: register offsets, field positions, reset values,
  protocol codes and timing counts.
  Assumes a 25 MHz core clock; all bit-time counts derive from it.
*/
`ifndef MBS_REGS_VH
`define MBS_REGS_VH

// Core clock rate
`define MBS_CLK_HZ        25000000

// Clock cycles per bit for each selectable rate
`define MBS_DIV_9600      12'd2604
`define MBS_DIV_14400     12'd1736
`define MBS_DIV_19200     12'd1302
`define MBS_DIV_38400     12'd651
`define MBS_DIV_57600     12'd434
`define MBS_DIV_115200    12'd217
`define MBS_BAUD_9600     3'h0
`define MBS_BAUD_14400    3'h1
`define MBS_BAUD_19200    3'h2
`define MBS_BAUD_38400    3'h3
`define MBS_BAUD_57600    3'h4
`define MBS_BAUD_115200   3'h5

// Frame gap: 3.5 characters of 11 bits is 38.5 bit times, rounded up
`define MBS_T35_BITS      18'd39

// Framing modes
`define MBS_FRM_NONE1     2'h0
`define MBS_FRM_EVEN1     2'h1
`define MBS_FRM_ODD1      2'h2
`define MBS_FRM_NONE2     2'h3

// Register offsets
`define MBS_REG_CONF      8'h00
`define MBS_REG_SLAVE     8'h01
`define MBS_REG_GOOD      8'h02
`define MBS_REG_DROP      8'h03
`define MBS_REG_STAT      8'h04

// Field positions of the configuration register
`define MBS_CONF_BAUD_LSB 0
`define MBS_CONF_BAUD_MSB 2
`define MBS_CONF_FRM_LSB  3
`define MBS_CONF_FRM_MSB  4

// Reset values
`define MBS_CONF_RST      5'h00
`define MBS_SLAVE_RST     8'h01
`define MBS_SLAVE_MAX     8'hF7

// Function and exception codes
`define MBS_FC_READ       8'h03
`define MBS_FC_WRITE      8'h10
`define MBS_FC_ID         8'h11
`define MBS_EXC_FLAG      8'h80
`define MBS_EXC_FUNC      8'h01
`define MBS_EXC_ADDR      8'h02
`define MBS_EXC_VALUE     8'h03
`define MBS_MAX_RD        16'h007D
`define MBS_MAX_WR        16'h007B
`define MBS_ADDR_TOP      17'h10000

// Check sequence
`define MBS_CRC_INIT      16'hFFFF
`define MBS_CRC_POLY      16'hA001

`endif

// File: hdl/mbs_slave.v
/*
  Serial slave port: receives request frames, answers read, write and identify requests,
  and reaches the holding register map over a simple request port.
  Assumes RXD is synchronous to CORE_CLK and the map answers one cycle after HR_RD or HR_WR.
*/
`include "mbs_regs.vh"

module mbs_slave #(
  parameter [7:0] ID_CODE = 8'h5A  // Arbitrary identification value
) (
  input  wire        CORE_CLK,
  input  wire        RST_B,
  input  wire [7:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [15:0] REG_RDATA,
  input  wire        RXD,
  output reg         TXD,
  output reg         TX_EN,
  output reg  [15:0] HR_ADDR,
  output reg  [15:0] HR_WDATA,
  output reg         HR_RD,
  output reg         HR_WR,
  input  wire [15:0] HR_RDATA,
  input  wire        HR_ERR
);

  localparam [2:0] R_IDLE  = 3'h0;
  localparam [2:0] R_START = 3'h1;
  localparam [2:0] R_DATA  = 3'h2;
  localparam [2:0] R_PAR   = 3'h3;
  localparam [2:0] R_STOP  = 3'h4;

  localparam [3:0] M_IDLE  = 4'h0;
  localparam [3:0] M_CHECK = 4'h1;
  localparam [3:0] M_RD    = 4'h2;
  localparam [3:0] M_RDW   = 4'h3;
  localparam [3:0] M_WR    = 4'h4;
  localparam [3:0] M_WRW   = 4'h5;
  localparam [3:0] M_SEND  = 4'h6;
  localparam [3:0] M_SHIFT = 4'h7;

  reg  [4:0]  conf;
  reg  [7:0]  slave_addr;
  reg  [15:0] good_cnt;
  reg  [15:0] drop_cnt;
  reg  [7:0]  mem [0:255];
  reg  [11:0] div;
  reg  [17:0] t35;
  reg  [2:0]  rx_st;
  reg  [11:0] rx_cnt;
  reg  [2:0]  rx_bit;
  reg  [7:0]  rx_sh;
  reg  [8:0]  rx_len;
  reg         rx_bad;
  reg  [17:0] idle_cnt;
  reg  [3:0]  m_state;
  reg  [8:0]  rlen;
  reg  [8:0]  tidx;
  reg  [7:0]  wptr;
  reg  [6:0]  nleft;
  reg  [15:0] cur;
  reg  [9:0]  tsh;
  reg  [3:0]  tleft;
  reg  [11:0] tcnt;
  reg  [7:0]  tbyte;
  integer     i;

  wire [1:0]  frm      = conf[`MBS_CONF_FRM_MSB:`MBS_CONF_FRM_LSB];
  wire        par_on   = (frm == `MBS_FRM_EVEN1) || (frm == `MBS_FRM_ODD1);
  wire        par_odd  = (frm == `MBS_FRM_ODD1);
  wire [15:0] rx_crc;
  wire [15:0] tx_crc;
  wire        rx_take  = (rx_st == R_STOP) && (rx_cnt == 12'h000);
  wire        byte_ok  = rx_take && RXD && (m_state == M_IDLE);
  wire        frame_in = (m_state == M_IDLE) && (idle_cnt == t35) && (rx_len != 9'h000);
  wire [15:0] start    = {mem[2], mem[3]};
  wire [15:0] qty      = {mem[4], mem[5]};
  wire [16:0] qend     = {1'b0, start} + {1'b0, qty};
  wire        body     = (m_state == M_SEND) && (tidx < rlen);

  // Bit period and frame gap follow the selected rate
  always @* begin
    case (conf[`MBS_CONF_BAUD_MSB:`MBS_CONF_BAUD_LSB])
      `MBS_BAUD_14400:  div = `MBS_DIV_14400;
      `MBS_BAUD_19200:  div = `MBS_DIV_19200;
      `MBS_BAUD_38400:  div = `MBS_DIV_38400;
      `MBS_BAUD_57600:  div = `MBS_DIV_57600;
      `MBS_BAUD_115200: div = `MBS_DIV_115200;
      default:          div = `MBS_DIV_9600;
    endcase
    t35 = {6'h00, div} * `MBS_T35_BITS;
  end

  // Byte being sent: frame body, then check low byte first
  always @* begin
    if (tidx < rlen) begin
      tbyte = mem[tidx[7:0]];
    end else if (tidx == rlen) begin
      tbyte = tx_crc[7:0];
    end else begin
      tbyte = tx_crc[15:8];
    end
  end

  // Running check over received bytes, restarted whenever the engine is busy
  mbs_crc16 u_rx_crc (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .init  (m_state != M_IDLE),
    .en    (byte_ok),
    .data  (rx_sh),
    .crc   (rx_crc)
  );

  // Check appended to the reply, built as the body goes out
  mbs_crc16 u_tx_crc (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .init  (m_state == M_IDLE),
    .en    (body),
    .data  (tbyte),
    .crc   (tx_crc)
  );

  // Software port; an out of range slave address is ignored
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      conf       <= `MBS_CONF_RST;
      slave_addr <= `MBS_SLAVE_RST;
      REG_RDATA  <= 16'h0000;
    end else begin
      if (REG_WR && REG_ADDR == `MBS_REG_CONF) begin
        conf <= REG_WDATA[4:0];
      end
      if (REG_WR && REG_ADDR == `MBS_REG_SLAVE && REG_WDATA[15:8] == 8'h00 &&
          REG_WDATA[7:0] != 8'h00 && REG_WDATA[7:0] <= `MBS_SLAVE_MAX) begin
        slave_addr <= REG_WDATA[7:0];
      end
      REG_RDATA <= 16'h0000;
      if (REG_RD) begin
        case (REG_ADDR)
          `MBS_REG_CONF:  REG_RDATA <= {11'h000, conf};
          `MBS_REG_SLAVE: REG_RDATA <= {8'h00, slave_addr};
          `MBS_REG_GOOD:  REG_RDATA <= good_cnt;
          `MBS_REG_DROP:  REG_RDATA <= drop_cnt;
          `MBS_REG_STAT:  REG_RDATA <= {7'h00, TX_EN, 1'b0, rx_st, m_state};
          default:        REG_RDATA <= 16'h0000;
        endcase
      end
    end
  end

  // Receiver: samples mid-bit; parity and stop errors spoil the frame
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_st  <= R_IDLE;
      rx_cnt <= 12'h000;
      rx_bit <= 3'h0;
      rx_sh  <= 8'h00;
    end else begin
      case (rx_st)
        R_IDLE: begin
          if (!RXD) begin
            rx_st  <= R_START;
            rx_cnt <= {1'b0, div[11:1]};
          end
        end
        R_START: begin
          if (rx_cnt != 12'h000) begin
            rx_cnt <= rx_cnt - 12'h001;
          end else if (RXD) begin
            rx_st <= R_IDLE;  // Glitch, not a start bit
          end else begin
            rx_st  <= R_DATA;
            rx_cnt <= div - 12'h001;
            rx_bit <= 3'h0;
          end
        end
        R_DATA: begin
          if (rx_cnt != 12'h000) begin
            rx_cnt <= rx_cnt - 12'h001;
          end else begin
            rx_sh  <= {RXD, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            rx_cnt <= div - 12'h001;
            if (rx_bit == 3'h7) begin
              rx_st <= par_on ? R_PAR : R_STOP;
            end
          end
        end
        R_PAR: begin
          if (rx_cnt != 12'h000) begin
            rx_cnt <= rx_cnt - 12'h001;
          end else begin
            rx_st  <= R_STOP;
            rx_cnt <= div - 12'h001;
          end
        end
        R_STOP: begin
          if (rx_cnt != 12'h000) begin
            rx_cnt <= rx_cnt - 12'h001;
          end else begin
            rx_st <= R_IDLE;  // Returns mid stop bit to catch the next start early
          end
        end
        default: rx_st <= R_IDLE;
      endcase
    end
  end

  // Silence timer delimits frames
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      idle_cnt <= 18'h00000;
    end else if (rx_st != R_IDLE || !RXD) begin
      idle_cnt <= 18'h00000;
    end else if (idle_cnt < t35) begin
      idle_cnt <= idle_cnt + 18'h00001;
    end
  end

  // Frame engine; bytes arriving while busy are lost, so a talking master breaks its own frame
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (i = 0; i < 256; i = i + 1) begin
        mem[i] <= 8'h00;
      end
      rx_len   <= 9'h000;
      rx_bad   <= 1'b0;
      m_state  <= M_IDLE;
      rlen     <= 9'h000;
      tidx     <= 9'h000;
      wptr     <= 8'h00;
      nleft    <= 7'h00;
      cur      <= 16'h0000;
      tsh      <= 10'h3FF;
      tleft    <= 4'h0;
      tcnt     <= 12'h000;
      good_cnt <= 16'h0000;
      drop_cnt <= 16'h0000;
      TXD      <= 1'b1;
      TX_EN    <= 1'b0;
      HR_ADDR  <= 16'h0000;
      HR_WDATA <= 16'h0000;
      HR_RD    <= 1'b0;
      HR_WR    <= 1'b0;
    end else begin
      HR_RD <= 1'b0;
      HR_WR <= 1'b0;
      case (m_state)
        M_IDLE: begin
          if (rx_take && m_state == M_IDLE) begin
            if (!RXD || (par_on && ((^rx_sh) ^ par_odd ^ rx_bad_par(rx_sh)))) begin
              rx_bad <= 1'b1;
            end
          end
          if (byte_ok) begin
            if (rx_len[8]) begin
              rx_bad <= 1'b1;  // Longer than any legal frame
            end else begin
              mem[rx_len[7:0]] <= rx_sh;
              rx_len           <= rx_len + 9'h001;
            end
          end
          if (frame_in) begin
            m_state <= M_CHECK;
          end
        end
        M_CHECK: begin
          rx_len  <= 9'h000;
          rx_bad  <= 1'b0;
          m_state <= M_IDLE;
          if (rx_bad || rx_len < 9'h004 || rx_crc != 16'h0000) begin
            drop_cnt <= drop_cnt + 16'h0001;
          end else if (mem[0] == 8'h00 || mem[0] != slave_addr) begin
            m_state <= M_IDLE;  // Broadcast and foreign frames get no reply
          end else begin
            m_state  <= M_SEND;
            tidx     <= 9'h000;
            TX_EN    <= 1'b1;  // Driver turns on only for a reply
            good_cnt <= good_cnt + 16'h0001;
            rlen     <= 9'h003;
            mem[1]   <= mem[1] | `MBS_EXC_FLAG;
            mem[2]   <= `MBS_EXC_FUNC;  // Anything else is an illegal function
            case (mem[1])
              `MBS_FC_READ: begin
                if (rx_len != 9'h008 || qty == 16'h0000 || qty > `MBS_MAX_RD) begin
                  mem[2] <= `MBS_EXC_VALUE;
                end else if (qend > `MBS_ADDR_TOP) begin
                  mem[2] <= `MBS_EXC_ADDR;
                end else begin
                  m_state <= M_RD;
                  TX_EN   <= 1'b0;
                  mem[1]  <= mem[1];
                  mem[2]  <= {qty[6:0], 1'b0};
                  cur     <= start;  // Wire number, one below the documented one
                  nleft   <= qty[6:0];
                  wptr    <= 8'h03;
                end
              end
              `MBS_FC_WRITE: begin
                if (qty == 16'h0000 || qty > `MBS_MAX_WR || mem[6] != {qty[6:0], 1'b0} ||
                    rx_len != {1'b0, mem[6]} + 9'h009) begin
                  mem[2] <= `MBS_EXC_VALUE;
                end else if (qend > `MBS_ADDR_TOP) begin
                  mem[2] <= `MBS_EXC_ADDR;
                end else begin
                  m_state <= M_WR;
                  TX_EN   <= 1'b0;
                  mem[1]  <= mem[1];
                  mem[2]  <= mem[2];
                  cur     <= start;
                  nleft   <= qty[6:0];
                  wptr    <= 8'h07;
                end
              end
              `MBS_FC_ID: begin
                mem[1] <= mem[1];
                mem[2] <= 8'h02;
                mem[3] <= ID_CODE;
                mem[4] <= 8'hFF;  // Run indicator: on
                rlen   <= 9'h005;
              end
              default: ;
            endcase
          end
        end
        M_RD: begin
          HR_RD   <= 1'b1;
          HR_ADDR <= cur;
          m_state <= M_RDW;
        end
        M_RDW: begin
          if (HR_RD) begin
            m_state <= M_RDW;  // Strobe cycle; the map answers at the next edge
          end else if (HR_ERR) begin
            mem[1]  <= mem[1] | `MBS_EXC_FLAG;
            mem[2]  <= `MBS_EXC_ADDR;  // Gap in the map
            rlen    <= 9'h003;
            tidx    <= 9'h000;
            TX_EN   <= 1'b1;
            m_state <= M_SEND;
          end else begin
            mem[wptr]         <= HR_RDATA[15:8];
            mem[wptr + 8'h01] <= HR_RDATA[7:0];
            wptr              <= wptr + 8'h02;
            cur               <= cur + 16'h0001;
            nleft             <= nleft - 7'h01;
            if (nleft == 7'h01) begin
              rlen    <= {1'b0, wptr} + 9'h002;
              tidx    <= 9'h000;
              TX_EN   <= 1'b1;
              m_state <= M_SEND;
            end else begin
              m_state <= M_RD;
            end
          end
        end
        M_WR: begin
          HR_WR    <= 1'b1;
          HR_ADDR  <= cur;
          HR_WDATA <= {mem[wptr], mem[wptr + 8'h01]};
          m_state  <= M_WRW;
        end
        M_WRW: begin
          if (HR_WR) begin
            m_state <= M_WRW;  // Strobe cycle; the error flag comes at the next edge
          end else if (HR_ERR) begin
            mem[1]  <= mem[1] | `MBS_EXC_FLAG;
            mem[2]  <= `MBS_EXC_ADDR;
            rlen    <= 9'h003;
            tidx    <= 9'h000;
            TX_EN   <= 1'b1;
            m_state <= M_SEND;
          end else begin
            wptr  <= wptr + 8'h02;
            cur   <= cur + 16'h0001;
            nleft <= nleft - 7'h01;
            if (nleft == 7'h01) begin
              rlen    <= 9'h006;  // Echo of address, function, start and count
              tidx    <= 9'h000;
              TX_EN   <= 1'b1;
              m_state <= M_SEND;
            end else begin
              m_state <= M_WR;
            end
          end
        end
        M_SEND: begin
          if (tidx == rlen + 9'h002) begin
            TX_EN   <= 1'b0;
            m_state <= M_IDLE;
          end else begin
            TXD     <= 1'b0;  // Start bit
            tsh     <= {1'b1, par_on ? (^tbyte ^ par_odd) : 1'b1, tbyte};
            tleft   <= (frm == `MBS_FRM_NONE1) ? 4'h9 : 4'hA;
            tcnt    <= div - 12'h001;
            tidx    <= tidx + 9'h001;
            m_state <= M_SHIFT;
          end
        end
        M_SHIFT: begin
          if (tcnt != 12'h000) begin
            tcnt <= tcnt - 12'h001;
          end else if (tleft == 4'h0) begin
            m_state <= M_SEND;
          end else begin
            TXD   <= tsh[0];
            tsh   <= {1'b1, tsh[9:1]};
            tleft <= tleft - 4'h1;
            tcnt  <= div - 12'h001;
          end
        end
        default: m_state <= M_IDLE;
      endcase
    end
  end

  // Received parity is the bit sampled in the parity slot
  reg par_seen;
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      par_seen <= 1'b0;
    end else if (rx_st == R_PAR && rx_cnt == 12'h000) begin
      par_seen <= RXD;
    end
  end

  function rx_bad_par;
    input [7:0] b;
    begin
      rx_bad_par = par_seen;
    end
  endfunction

endmodule

// File: verification/mbs_master_model.sv
/*
  Behavioural single master on the serial line: sends requests, collects replies.
  Assumes the slave is already set to the bit period BIT, eight data bits, no parity, one stop.
*/
module mbs_master_model #(
  parameter int BIT = 217
) (
  input  wire logic clk,
  output logic      rxd,
  input  wire logic txd,
  input  wire logic tx_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] b;

  // Bias keeps the released line high; only this master drives it
  initial rxd = 1'b1;

  // Reflected check sequence, all ones at start
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction

  // Start bit, data LSB first, one stop bit at the agreed rate
  task automatic put_byte(input logic [7:0] d);
    logic [9:0] sh;
    sh = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= sh[i];
      repeat (BIT) @(posedge clk);
    end
  endtask

  // Gap, body, check low byte first; caller waits for the reply before the next
  task automatic send(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    repeat (40 * BIT) @(posedge clk);
    foreach (q[i]) put_byte(q[i]);
  endtask

  // Reply collector; samples on the falling edge so it never races the slave's flops
  initial forever begin
    @(negedge clk);
    if (tx_en === 1'b1 && txd === 1'b0) begin
      repeat (BIT / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge clk);
        b[i] = txd;
      end
      repeat (BIT) @(negedge clk);
      got.push_back(b);
    end
  end
endmodule

// File: verification/mbs_slave_checker.sv
/*
  Property checker for the serial slave port, bound to its top module.
  Assumes one core clock; the fastest bit rate gives the lower bounds on gaps and replies.
*/
`include "mbs_regs.vh"

module mbs_slave_checker (
  input wire        CORE_CLK,
  input wire        RST_B,
  input wire [7:0]  REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire        REG_WR,
  input wire        REG_RD,
  input wire [15:0] REG_RDATA,
  input wire        RXD,
  input wire        TXD,
  input wire        TX_EN,
  input wire [15:0] HR_ADDR,
  input wire [15:0] HR_WDATA,
  input wire        HR_RD,
  input wire        HR_WR,
  input wire [15:0] HR_RDATA,
  input wire        HR_ERR
);
  timeunit 1ns;
  timeprecision 1ns;
  // Gap is 39 bits at the fastest rate; five characters at least, a little slack for edges
  localparam int QUIET  = 39 * 217;
  localparam int MIN_TX = 50 * 217 - 4;
  logic [15:0] quiet;
  logic [23:0] tx_len;
  logic        heard;

  // Idle run on the line, reply length, and a request seen since the last reply
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      quiet  <= 16'h0000;
      tx_len <= 24'h000000;
      heard  <= 1'b0;
    end else begin
      quiet  <= !RXD ? 16'h0000 : ((quiet == 16'hFFFF) ? quiet : quiet + 16'h0001);
      tx_len <= TX_EN ? tx_len + 24'h000001 : 24'h000000;
      heard  <= !RXD ? 1'b1 : (TX_EN ? 1'b0 : heard);
    end
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  // A finished request: line went low, then stayed high for a full gap
  sequence s_request_done;
    heard && quiet >= QUIET;
  endsequence
  sequence s_start_bit;
    ##[0:1] !TXD;
  endsequence

  a_reset_quiet: assert property ($rose(RST_B) |-> TXD && !TX_EN && !HR_RD && !HR_WR)
    else $error("outputs not idle after reset");
  a_reply_after_request: assert property ($rose(TX_EN) |-> s_request_done)
    else $error("reply started without a delimited request");
  a_reply_start_bit: assert property ($rose(TX_EN) |-> s_start_bit)
    else $error("reply does not open with a start bit");
  a_reply_min_length: assert property ($fell(TX_EN) |-> tx_len >= MIN_TX)
    else $error("reply shorter than five characters");
  a_idle_line_high: assert property (!TX_EN |-> TXD)
    else $error("transmit line low while driver is off");
  a_map_single_pulse: assert property (HR_RD |=> !HR_RD && !HR_WR)
    else $error("map requests closer than two cycles");
  a_map_one_strobe: assert property (!(HR_RD && HR_WR))
    else $error("map read and write at once");
  a_map_after_frame: assert property (HR_RD || HR_WR |-> s_request_done)
    else $error("map access without a delimited request");
  a_rdata_one_cycle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
    else $error("read data outside its cycle");
  a_slave_in_range: assert property (REG_RD && REG_ADDR == `MBS_REG_SLAVE |=>
    REG_RDATA >= 16'h0001 && REG_RDATA <= 16'h00F7) else $error("slave address out of range");
endmodule

bind mbs_slave mbs_slave_checker mbs_slave_checker_inst (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RXD(RXD), .TXD(TXD), .TX_EN(TX_EN), .HR_ADDR(HR_ADDR),
  .HR_WDATA(HR_WDATA), .HR_RD(HR_RD), .HR_WR(HR_WR), .HR_RDATA(HR_RDATA), .HR_ERR(HR_ERR)
);

// File: verification/mbs_slave_test.sv
/*
  Self-checking bench for the serial slave port: register access, read, silent and identify frames.
  Assumes the master model and a small holding map answering one cycle after a request.
*/
`include "mbs_regs.vh"

module mbs_slave_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         BIT = 217;
  localparam logic [7:0] ID  = 8'hC3;  // Arbitrary identification value
  logic        CORE_CLK = 1'b0;
  logic        RST_B    = 1'b0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [15:0] REG_WDATA = 16'h0000;
  logic        REG_WR   = 1'b0;
  logic        REG_RD   = 1'b0;
  logic [15:0] HR_RDATA = 16'h0000;
  logic        HR_ERR   = 1'b0;
  logic [15:0] hr_addr  = 16'h0000;
  logic [15:0] hr_n     = 16'h0000;
  logic [15:0] hr_wdata = 16'h0000;
  wire  [15:0] REG_RDATA, HR_ADDR, HR_WDATA;
  wire         RXD, TXD, TX_EN, HR_RD, HR_WR;
  int          n_errors   = 0;
  int          n_compared = 0;

  always #20 CORE_CLK = ~CORE_CLK;

  mbs_slave #(.ID_CODE(ID)) mbs_slave_inst (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .RXD(RXD), .TXD(TXD), .TX_EN(TX_EN), .HR_ADDR(HR_ADDR),
    .HR_WDATA(HR_WDATA), .HR_RD(HR_RD), .HR_WR(HR_WR), .HR_RDATA(HR_RDATA), .HR_ERR(HR_ERR)
  );
  mbs_master_model #(.BIT(BIT)) mbs_master_model_inst (.clk(CORE_CLK), .rxd(RXD), .txd(TXD), .tx_en(TX_EN));

  // Holding map: answers a read next cycle, otherwise shows a changing pattern
  always @(posedge CORE_CLK) begin
    HR_RDATA <= HR_RD ? 16'hBEEF : ~HR_RDATA;
    HR_ERR   <= (HR_RD || HR_WR) && HR_ADDR == 16'h0010;  // One gap in the map
    if (HR_RD || HR_WR) begin
      hr_addr <= HR_ADDR;
      hr_n    <= hr_n + 16'h0001;
    end
    if (HR_WR) begin
      hr_wdata <= HR_WDATA;
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic reg_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD   <= 1'b0;
    #1;
    check($sformatf("register %0h", a), exp, REG_RDATA);
  endtask

  // Waits bounded for the whole reply, check bytes included
  task automatic expect_reply(input logic [7:0] q[$]);
    logic [15:0] c;
    int          k;
    c = mbs_master_model_inst.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    k = 0;
    while (mbs_master_model_inst.got.size() < q.size() && k < 40000) begin
      @(posedge CORE_CLK);
      k++;
    end
    check("reply length", 16'(q.size()), 16'(mbs_master_model_inst.got.size()));
    if (k == 40000) tally_and_finish();
    foreach (q[i]) check("reply byte", q[i], mbs_master_model_inst.got[i]);
    mbs_master_model_inst.got.delete();
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    reg_chk(`MBS_REG_CONF, 16'h0000);
    reg_chk(`MBS_REG_SLAVE, 16'h0001);
    reg_chk(`MBS_REG_GOOD, 16'h0000);
    reg_chk(`MBS_REG_DROP, 16'h0000);
    reg_chk(8'h07, 16'h0000);
    reg_wr(`MBS_REG_SLAVE, 16'h00F8);
    reg_chk(`MBS_REG_SLAVE, 16'h0001);
    reg_wr(`MBS_REG_SLAVE, 16'h002A);
    reg_chk(`MBS_REG_SLAVE, 16'h002A);
    reg_wr(`MBS_REG_CONF, {11'h000, `MBS_FRM_NONE1, `MBS_BAUD_115200});
    reg_chk(`MBS_REG_CONF, 16'h0005);
    // One register at wire address 5
    mbs_master_model_inst.send({8'h2A, 8'h03, 8'h00, 8'h05, 8'h00, 8'h01});
    expect_reply({8'h2A, 8'h03, 8'h02, 8'hBE, 8'hEF});
    check("map address", 16'h0005, hr_addr);
    check("map reads", 16'h0001, hr_n);
    // Broadcast identify must stay unanswered past the gap
    mbs_master_model_inst.send({8'h00, 8'h11});
    repeat (39 * BIT + 1500) @(posedge CORE_CLK);
    #1;
    check("broadcast reply", 16'h0000, 16'(mbs_master_model_inst.got.size()));
    check("driver enable", 16'h0000, {15'h0000, TX_EN});
    mbs_master_model_inst.send({8'h2A, 8'h11});
    expect_reply({8'h2A, 8'h11, 8'h02, ID, 8'hFF});
    reg_chk(`MBS_REG_GOOD, 16'h0002);
    // Single-register write into the gap: data reach the map, exception comes back
    mbs_master_model_inst.send({8'h2A, 8'h10, 8'h00, 8'h10, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34});
    expect_reply({8'h2A, 8'h90, 8'h02});
    check("map write address", 16'h0010, hr_addr);
    check("map write data", 16'h1234, hr_wdata);
    reg_chk(`MBS_REG_GOOD, 16'h0003);
    tally_and_finish();
  end
endmodule
